// *** core/encoder_command_status_bank.sv ***
`timescale 1ns/1ps
`include "enc_bank_regs.svh"
// Notes on behaviour
// - command word zero: nothing is sent to the encoder, no action taken.
// - writing one asks the encoder to clear its latched battery error.
// - writing two asks the encoder to zero its accumulated revolution count.
// - turn counter overflow alert stays set until the command word gets two.
// - feedback kind reads 0 absent or unknown, 1 single-turn, 2 multi-turn.
// - encoder temperature reads as signed 16-bit degrees; writes cannot change it.
// - version word: hardware in top byte, firmware major, minor, patch below.
// - error bit 0 means returned position values are untrustworthy.
// - error bit 1 flags temperature too high, bit 2 temperature too low.
// - error bit 3 flags missing or corrupt calibration, position undecodable.
// - error bit 4 flags encoder supply below operating level.
// - error bit 5 flags multi-turn battery below three volts.
// - error bit 6 flags multi-turn encoder needing a configuration command.
// - error bit 7 flags multi-turn versus single-turn position sync fault.
// - error bit 8 flags a generic multi-turn module fault.
// - error bits 16 to 23 carry the internal encoder error.
// - error bit 24 flags firmware incompatible with the encoder hardware.
module encoder_command_status_bank
  import enc_bank_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire par_req_t      par_req_i,
  output logic [31:0]        par_rdata_o,
  output logic               par_rvalid_o,
  output logic               par_err_o,
  input  wire logic [15:0]   feedback_kind_i,
  input  wire logic [15:0]   enc_temp_i,
  input  wire enc_version_t  enc_version_i,
  input  wire enc_fault_t    enc_fault_i,
  input  wire logic          turn_overflow_i,
  input  wire logic          cmd_ack_i,
  output logic               cmd_valid_o,
  output enc_cmd_t           cmd_code_o,
  output logic               turn_overflow_alert_o
);

  // error word layout from the fault inputs; unused bits forced low
  function automatic logic [31:0] pack_faults(input enc_fault_t f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ENC_ERR_POS_BIT]                  = f.pos_untrusted;
    w[`ENC_ERR_TEMP_HI_BIT]              = f.temp_high;
    w[`ENC_ERR_TEMP_LO_BIT]              = f.temp_low;
    w[`ENC_ERR_UNCAL_BIT]                = f.uncalibrated;
    w[`ENC_ERR_SUPPLY_BIT]               = f.supply_low;
    w[`ENC_ERR_BATT_BIT]                 = f.battery_low;
    w[`ENC_ERR_CONFIG_BIT]               = f.needs_config;
    w[`ENC_ERR_SYNC_BIT]                 = f.sync_err;
    w[`ENC_ERR_MT_GEN_BIT]               = f.mt_generic;
    w[`ENC_ERR_INT_MSB:`ENC_ERR_INT_LSB] = f.internal_err;
    w[`ENC_ERR_FW_HW_BIT]                = f.fw_hw_mismatch;
    return w & `ENC_ERR_MASK;
  endfunction : pack_faults

  // out-of-range kind codes are reported as undetermined feedback
  function automatic logic [15:0] map_kind(input logic [15:0] k);
    return (k > `ENC_KIND_MULTI) ? `ENC_KIND_NONE : k;
  endfunction : map_kind

  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  cmd_state_t  state_reg;
  cmd_state_t  state_next;
  logic [15:0] kind_reg;
  logic [15:0] temp_reg;
  logic [31:0] ver_reg;
  logic [31:0] err_reg;
  logic        alert_reg;
  logic        alert_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        err_out_reg;
  logic        err_out_next;

  // address decode
  wire hit_cmd  = (par_req_i.addr == `ENC_CMD_ADDR);
  wire hit_kind = (par_req_i.addr == `ENC_KIND_ADDR);
  wire hit_temp = (par_req_i.addr == `ENC_TEMP_ADDR);
  wire hit_ver  = (par_req_i.addr == `ENC_VER_ADDR);
  wire hit_err  = (par_req_i.addr == `ENC_ERR_ADDR);
  wire hit_any  = hit_cmd | hit_kind | hit_temp | hit_ver | hit_err;

  // a new command is refused while the previous one is still in flight,
  // so the encoder never sees a code change under a pending request
  wire [15:0] wr_val    = par_req_i.wdata[15:0];
  wire        wr_cmd    = par_req_i.wr & hit_cmd;
  wire        val_ok    = (wr_val <= `ENC_CMD_MAX) & (par_req_i.wdata[31:16] == 16'h0000);
  wire        cmd_taken = wr_cmd & val_ok & (state_reg == ST_IDLE);
  wire        wr_bad    = par_req_i.wr & ~cmd_taken;
  wire        rd_bad    = par_req_i.rd & ~hit_any;
  wire        zero_rev  = cmd_taken & (wr_val == `ENC_CMD_ZERO_REV);

  // command handshake towards the encoder
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_taken) begin
          cmd_next = wr_val;
          if (wr_val != `ENC_CMD_NONE) begin
            state_next = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (cmd_ack_i) begin
          state_next = ST_IDLE;
          cmd_next   = `ENC_CMD_NONE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cmd_next   = `ENC_CMD_NONE;
      end
    endcase
  end

  // overflow event wins over a clear arriving in the same cycle
  assign alert_next = turn_overflow_i | (alert_reg & ~zero_rev);

  // read mux
  wire [31:0] rd_mux = hit_cmd  ? {16'h0000, cmd_reg} :
                       hit_kind ? {16'h0000, kind_reg} :
                       hit_temp ? {16'h0000, temp_reg} :
                       hit_ver  ? ver_reg :
                       hit_err  ? err_reg : 32'h0000_0000;
  assign rdata_next   = par_req_i.rd ? rd_mux : rdata_reg;
  assign err_out_next = wr_bad | rd_bad;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cmd_reg   <= `ENC_CMD_RST;
      alert_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      alert_reg <= alert_next;
    end
  end

  // status words follow the encoder inputs; the bus never writes them
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_reg <= `ENC_KIND_RST;
      temp_reg <= `ENC_TEMP_RST;
      ver_reg  <= `ENC_VER_RST;
      err_reg  <= `ENC_ERR_RST;
    end else begin
      kind_reg <= map_kind(feedback_kind_i);
      temp_reg <= enc_temp_i;
      ver_reg  <= enc_version_i;
      err_reg  <= pack_faults(enc_fault_i);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg   <= 32'h0000_0000;
      rvalid_reg  <= 1'b0;
      err_out_reg <= 1'b0;
    end else begin
      rdata_reg   <= rdata_next;
      rvalid_reg  <= par_req_i.rd;
      err_out_reg <= err_out_next;
    end
  end

  assign par_rdata_o           = rdata_reg;
  assign par_rvalid_o          = rvalid_reg;
  assign par_err_o             = err_out_reg;
  assign cmd_valid_o           = (state_reg == ST_SEND);
  assign cmd_code_o            = enc_cmd_t'(cmd_reg[1:0]);
  assign turn_overflow_alert_o = alert_reg;

  sequence write_cmd_s(logic [15:0] v);
    (par_req_i.wr && hit_cmd && par_req_i.wdata == {16'h0000, v} && state_reg == ST_IDLE);
  endsequence

  sequence send_s(enc_cmd_t c);
    (cmd_valid_o && cmd_code_o == c);
  endsequence

  no_cmd_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cmd_reg == `ENC_CMD_NONE) |-> !cmd_valid_o)
    else $error("command sent while command word is zero");

  clr_batt_send_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_cmd_s(`ENC_CMD_CLR_BATT) |=> send_s(CMD_CLR_BATT))
    else $error("battery clear not sent after write of one");

  zero_rev_send_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_cmd_s(`ENC_CMD_ZERO_REV) |=> send_s(CMD_ZERO_TURNS))
    else $error("revolution reset not sent after write of two");

  send_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cmd_valid_o && !cmd_ack_i) |=> (cmd_valid_o && $stable(cmd_code_o)))
    else $error("command dropped before acknowledge");

  alert_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (alert_reg && !zero_rev) |=> alert_reg)
    else $error("overflow alert cleared without command two");

  alert_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    turn_overflow_i |=> turn_overflow_alert_o)
    else $error("overflow event lost");

  kind_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (kind_reg == ((($past(feedback_kind_i)) > `ENC_KIND_MULTI) ? `ENC_KIND_NONE : $past(feedback_kind_i))))
    else $error("feedback kind misreported");

  // read data is the input as sampled one edge before the read request
  temp_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.rd && hit_temp) |=> (par_rvalid_o && par_rdata_o == {16'h0000, $past(enc_temp_i, 2)}))
    else $error("temperature read does not match input");

  ver_layout_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (ver_reg[31:24] == $past(enc_version_i.hw) && ver_reg[7:0] == $past(enc_version_i.fw_patch)))
    else $error("version word layout wrong");

  err_bits_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[0] == $past(enc_fault_i.pos_untrusted) && err_reg[5] == $past(enc_fault_i.battery_low)
      && err_reg[24] == $past(enc_fault_i.fw_hw_mismatch) && err_reg[23:16] == $past(enc_fault_i.internal_err)))
    else $error("error word bit mapping wrong");

  err_reserved_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (err_reg & ~`ENC_ERR_MASK) == 32'h0000_0000)
    else $error("reserved error bit set");

  ro_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.wr && (hit_kind || hit_temp || hit_ver || hit_err)) |=> par_err_o)
    else $error("write to read-only word not refused");

  temp_bits_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[1] == $past(enc_fault_i.temp_high) && err_reg[2] == $past(enc_fault_i.temp_low)))
    else $error("temperature error bits wrong");

  uncal_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[3] == $past(enc_fault_i.uncalibrated)))
    else $error("calibration error bit wrong");

  supply_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[4] == $past(enc_fault_i.supply_low)))
    else $error("supply error bit wrong");

  battery_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[5] == $past(enc_fault_i.battery_low)))
    else $error("battery error bit wrong");

  config_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[6] == $past(enc_fault_i.needs_config)))
    else $error("configuration error bit wrong");

  sync_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[7] == $past(enc_fault_i.sync_err)))
    else $error("synchronisation error bit wrong");

  mt_generic_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[8] == $past(enc_fault_i.mt_generic)))
    else $error("multi-turn generic error bit wrong");

  internal_err_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[23:16] == $past(enc_fault_i.internal_err)))
    else $error("internal error field wrong");

  fw_hw_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (err_reg[24] == $past(enc_fault_i.fw_hw_mismatch)))
    else $error("firmware mismatch bit wrong");

  err_gap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (err_reg[15:9] == 7'h00 && err_reg[31:25] == 7'h00))
    else $error("unused error bits set");

  ver_fw_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (ver_reg[23:16] == $past(enc_version_i.fw_major) && ver_reg[15:8] == $past(enc_version_i.fw_minor)))
    else $error("firmware version bytes wrong");

  temp_copy_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (temp_reg == $past(enc_temp_i)))
    else $error("temperature word does not follow input");

  // a write to the temperature word must not disturb what is shown
  temp_ro_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.wr && hit_temp) |=> (par_err_o && temp_reg == $past(enc_temp_i)))
    else $error("temperature word changed by a write");

  ack_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cmd_valid_o && cmd_ack_i) |=> (!cmd_valid_o && cmd_reg == `ENC_CMD_NONE))
    else $error("command not retired after acknowledge");

  busy_refuse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cmd_valid_o && !cmd_ack_i && par_req_i.wr && hit_cmd) |=> (par_err_o && cmd_valid_o && $stable(cmd_code_o)))
    else $error("command overwritten while pending");

  zero_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_cmd_s(`ENC_CMD_NONE) |=> !cmd_valid_o)
    else $error("command sent after write of zero");

  send_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(cmd_valid_o) |-> ($past(cmd_taken) && $past(wr_val) != `ENC_CMD_NONE))
    else $error("command started without a non-zero write");

  code_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_valid_o |-> (cmd_code_o == CMD_CLR_BATT || cmd_code_o == CMD_ZERO_TURNS))
    else $error("pending command code out of range");

  cmd_accept_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_cmd_s(`ENC_CMD_ZERO_REV) |=> !par_err_o)
    else $error("valid command write refused");

  alert_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (zero_rev && !turn_overflow_i) |=> !alert_reg)
    else $error("overflow alert not cleared by command two");

  // set wins: an overflow in the clearing cycle keeps the alert
  alert_race_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (zero_rev && turn_overflow_i) |=> alert_reg)
    else $error("overflow lost against a clear");

  rvalid_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    par_req_i.rd |=> par_rvalid_o)
    else $error("read not answered");

  rvalid_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !par_req_i.rd |=> !par_rvalid_o)
    else $error("read valid without a read");

  kind_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.rd && hit_kind) |=> (par_rdata_o[31:16] == 16'h0000 && par_rdata_o[15:0] <= `ENC_KIND_MULTI))
    else $error("feedback kind read out of range");

  ver_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.rd && hit_ver) |=> (par_rdata_o == $past(ver_reg)))
    else $error("version read wrong");

  err_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.rd && hit_err) |=> (par_rdata_o == $past(err_reg)))
    else $error("error word read wrong");

  unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (par_req_i.rd && !hit_any) |=> (par_err_o && par_rdata_o == 32'h0000_0000))
    else $error("unmapped read not refused");

  err_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!par_req_i.rd && !par_req_i.wr) |=> !par_err_o)
    else $error("error pulse without a request");

endmodule : encoder_command_status_bank

// *** core/enc_bank_regs.svh ***
`ifndef ENC_BANK_REGS_SVH
`define ENC_BANK_REGS_SVH

// parameter addresses as seen by the fieldbus master
`define ENC_CMD_ADDR      16'h0958
`define ENC_KIND_ADDR     16'h095a
`define ENC_TEMP_ADDR     16'h095c
`define ENC_VER_ADDR      16'h095e
`define ENC_ERR_ADDR      16'h0960

// command word values
`define ENC_CMD_NONE      16'h0000
`define ENC_CMD_CLR_BATT  16'h0001
`define ENC_CMD_ZERO_REV  16'h0002
`define ENC_CMD_MAX       16'h0002

// feedback kind values
`define ENC_KIND_NONE     16'h0000
`define ENC_KIND_SINGLE   16'h0001
`define ENC_KIND_MULTI    16'h0002

// error word bit positions
`define ENC_ERR_POS_BIT      0
`define ENC_ERR_TEMP_HI_BIT  1
`define ENC_ERR_TEMP_LO_BIT  2
`define ENC_ERR_UNCAL_BIT    3
`define ENC_ERR_SUPPLY_BIT   4
`define ENC_ERR_BATT_BIT     5
`define ENC_ERR_CONFIG_BIT   6
`define ENC_ERR_SYNC_BIT     7
`define ENC_ERR_MT_GEN_BIT   8
`define ENC_ERR_INT_LSB      16
`define ENC_ERR_INT_MSB      23
`define ENC_ERR_FW_HW_BIT    24
`define ENC_ERR_MASK         32'h01ff_01ff

// reset values
`define ENC_CMD_RST       16'h0000
`define ENC_KIND_RST      16'h0000
`define ENC_TEMP_RST      16'h0000
`define ENC_VER_RST       32'h0000_0000
`define ENC_ERR_RST       32'h0000_0000

`endif

// *** core/enc_bank_pkg.sv ***
package enc_bank_pkg;

  typedef enum logic [1:0] {
    CMD_NONE       = 2'b00,
    CMD_CLR_BATT   = 2'b01,
    CMD_ZERO_TURNS = 2'b10
  } enc_cmd_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } cmd_state_t;

  typedef struct packed {
    logic [7:0] hw;
    logic [7:0] fw_major;
    logic [7:0] fw_minor;
    logic [7:0] fw_patch;
  } enc_version_t;

  typedef struct packed {
    logic       fw_hw_mismatch;
    logic [7:0] internal_err;
    logic       mt_generic;
    logic       sync_err;
    logic       needs_config;
    logic       battery_low;
    logic       supply_low;
    logic       uncalibrated;
    logic       temp_low;
    logic       temp_high;
    logic       pos_untrusted;
  } enc_fault_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } par_req_t;

endpackage : enc_bank_pkg

// *** tb/enc_ack_model.sv ***
`timescale 1ns/1ps
// encoder side of the command link: acks a pending command delay_i + 1 cycles after it appears
module enc_ack_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [3:0] delay_i,
  output logic            cmd_ack_o
);
  logic [3:0] wait_reg;

  // single-cycle ack; no ack while idle, like a real encoder
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg  <= 4'h0;
      cmd_ack_o <= 1'b0;
    end else begin
      cmd_ack_o <= 1'b0;
      if (cmd_valid_i && !cmd_ack_o) begin
        if (wait_reg >= delay_i) begin
          cmd_ack_o <= 1'b1;
          wait_reg  <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule : enc_ack_model

// *** tb/test_encoder_command_status_bank.sv ***
`timescale 1ns/1ps
`include "enc_bank_regs.svh"
module test_encoder_command_status_bank import enc_bank_pkg::*;;
  logic         core_clk, rst_n, ack, vld, rv, er, alert, ovf;
  par_req_t     req;
  logic [31:0]  rdata, rdat;
  logic         rvalid, err;
  logic [15:0]  kind, temp;
  enc_version_t ver;
  enc_fault_t   fault;
  enc_cmd_t     code;
  logic [3:0]   dly;
  int           failures = 0;
  int           n_tests  = 0;

  encoder_command_status_bank u_encoder_command_status_bank (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .par_req_i(req), .par_rdata_o(rdata),
    .par_rvalid_o(rvalid), .par_err_o(err), .feedback_kind_i(kind), .enc_temp_i(temp),
    .enc_version_i(ver), .enc_fault_i(fault), .turn_overflow_i(ovf), .cmd_ack_i(ack),
    .cmd_valid_o(vld), .cmd_code_o(code), .turn_overflow_alert_o(alert));

  enc_ack_model u_enc_ack_model (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .cmd_valid_i(vld), .delay_i(dly), .cmd_ack_o(ack));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one request cycle; results are sampled just after the answering edge
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge core_clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
    #1;
    rdat = rdata;
    rv   = rvalid;
    er   = err;
  endtask : bus

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    chk("rvalid", 32'h1, {31'h0, rv});
    chk(name, exp, rdat);
  endtask : rd_chk

  task automatic wait_idle();
    for (int i = 0; i < 20 && vld !== 1'b0; i++) @(posedge core_clk);
    #1;
    chk("cmd_valid", 32'h0, {31'h0, vld});
  endtask : wait_idle

  task automatic t_kind();
    for (int k = 0; k < 4; k++) begin
      kind <= 16'(k);
      rd_chk("kind", `ENC_KIND_ADDR, (k > 2) ? 32'h0 : 32'(k));
    end
    $display("test kind done");
  endtask : t_kind

  task automatic t_status();
    logic [31:0] e;
    temp  <= 16'hffe0;
    ver   <= '{hw: 8'h5a, fw_major: 8'h01, fw_minor: 8'h02, fw_patch: 8'h03};
    fault <= '1;
    rd_chk("temp", `ENC_TEMP_ADDR, 32'h0000_ffe0);
    rd_chk("version", `ENC_VER_ADDR, 32'h5a01_0203);
    rd_chk("errors", `ENC_ERR_ADDR, 32'h01ff_01ff);
    for (int i = 0; i < 18; i++) begin
      fault <= enc_fault_t'(18'h1 << i);
      e = (i < 9) ? (32'h1 << i) : (i == 17) ? 32'h0100_0000 : (32'h1 << (i + 7));
      rd_chk("error bit", `ENC_ERR_ADDR, e);
    end
    bus(1'b1, 1'b0, `ENC_TEMP_ADDR, 32'h0000_1234);
    chk("ro write err", 32'h1, {31'h0, er});
    rd_chk("temp kept", `ENC_TEMP_ADDR, 32'h0000_ffe0);
    rd_chk("unmapped", 16'h0962, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("test status done");
  endtask : t_status

  task automatic t_cmd();
    dly <= 4'h6;
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h0);
    chk("no command", 32'h0, {31'h0, vld});
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h1);
    chk("clr valid", 32'h1, {31'h0, vld});
    chk("clr code", 32'(CMD_CLR_BATT), {30'h0, code});
    rd_chk("cmd word", `ENC_CMD_ADDR, 32'h1);
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h2);
    chk("busy err", 32'h1, {31'h0, er});
    wait_idle();
    rd_chk("cmd cleared", `ENC_CMD_ADDR, 32'h0);
    dly <= 4'h0;
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h3);
    chk("range err", 32'h1, {31'h0, er});
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h2);
    chk("zero code", 32'(CMD_ZERO_TURNS), {30'h0, code});
    wait_idle();
    $display("test command done");
  endtask : t_cmd

  task automatic t_alert();
    dly <= 4'h2;
    ovf <= 1'b1;
    @(posedge core_clk);
    ovf <= 1'b0;
    #1;
    chk("alert set", 32'h1, {31'h0, alert});
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h1);
    wait_idle();
    chk("alert kept", 32'h1, {31'h0, alert});
    bus(1'b1, 1'b0, `ENC_CMD_ADDR, 32'h2);
    chk("alert cleared", 32'h0, {31'h0, alert});
    wait_idle();
    $display("test alert done");
  endtask : t_alert

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    #40000;
    failures++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    req   = '0;
    kind  = 16'h0;
    temp  = 16'h0;
    ver   = '0;
    fault = '0;
    ovf   = 1'b0;
    dly   = 4'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("reset valid", 32'h0, {31'h0, vld});
    t_kind();
    t_status();
    t_cmd();
    t_alert();
    stop_test();
  end
endmodule : test_encoder_command_status_bank
